// ---- pkg/pioc_map.svh ----
// constants of the parallel line controller: masks, reset values, timing
`ifndef PIOC_MAP_SVH
`define PIOC_MAP_SVH

// ------------------------------------------------------------
// line population
// ------------------------------------------------------------
`define PIOC_LINES        32
`define PIOC_IMPL_MASK    32'hffffffff
`define PIOC_MUX_MASK     32'h0fffffff

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PIOC_OWN_RST      32'hffffffff
`define PIOC_PULLOFF_RST  32'h00000000
`define PIOC_CHOICE_RST   32'h00000000
`define PIOC_DRIVE_RST    32'h00000000
`define PIOC_LEVEL_RST    32'h00000000
`define PIOC_MASK_RST     32'h00000000
`define PIOC_OD_RST       32'h00000000
`define PIOC_FILT_RST     32'h00000000
`define PIOC_IRQM_RST     32'h00000000
`define PIOC_EVT_RST      32'h00000000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PIOC_CLK_PERIOD_NS 100

`endif

// ---- pkg/pioc_pkg.sv ----
// types of the parallel line controller
package pioc_pkg;

    // ------------------------------------------------------------
    // write commands
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        PIOC_CMD_NONE,
        PIOC_CMD_OWN_SET,
        PIOC_CMD_OWN_CLR,
        PIOC_CMD_PERIPH_A,
        PIOC_CMD_PERIPH_B,
        PIOC_CMD_DRIVE_SET,
        PIOC_CMD_DRIVE_CLR,
        PIOC_CMD_LEVEL_SET,
        PIOC_CMD_LEVEL_CLR,
        PIOC_CMD_LEVEL_DIRECT,
        PIOC_CMD_WMASK_SET,
        PIOC_CMD_WMASK_CLR,
        PIOC_CMD_OD_SET,
        PIOC_CMD_OD_CLR,
        PIOC_CMD_PULL_ON,
        PIOC_CMD_PULL_OFF,
        PIOC_CMD_FILT_SET,
        PIOC_CMD_FILT_CLR,
        PIOC_CMD_IRQ_SET,
        PIOC_CMD_IRQ_CLR
    } pioc_cmd_t;

    typedef logic [31:0] pioc_word_t;

endpackage : pioc_pkg

// ---- logic/pioc_glitch_filter.sv ----
// input glitch filter: one extra sample stage on filtered lines
`timescale 1ns/1ps
`default_nettype none
`include "pioc_map.svh"

module pioc_glitch_filter (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // sampling enable
    input  wire logic                 sampleEn,
    // levels
    input  wire pioc_pkg::pioc_word_t rawIn,
    input  wire pioc_pkg::pioc_word_t filterOn,
    output pioc_pkg::pioc_word_t      cleanOut
);
    import pioc_pkg::*;

    pioc_word_t stage;

    // ------------------------------------------------------------
    // extra stage, then per-line choice
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage <= `PIOC_LEVEL_RST;
        end else if (sampleEn) begin
            stage <= rawIn;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `PIOC_LINES; i++) begin : g_line
            // filtered lines take the delayed sample from the extra stage [R19] [R18]
            assign cleanOut[i] = filterOn[i] ? stage[i] : rawIn[i];
        end
    endgenerate

endmodule // pioc_glitch_filter

`default_nettype wire

// ---- logic/pioc_pad_mux.sv ----
// per-line output path: owner choice, peripheral a/b choice, open drain
`timescale 1ns/1ps
`default_nettype none
`include "pioc_map.svh"

module pioc_pad_mux (
    // line configuration
    input  wire pioc_pkg::pioc_word_t ownCtl,
    input  wire pioc_pkg::pioc_word_t choiceB,
    input  wire pioc_pkg::pioc_word_t drive,
    input  wire pioc_pkg::pioc_word_t level,
    input  wire pioc_pkg::pioc_word_t openDrain,
    // peripheral a and b output paths
    input  wire pioc_pkg::pioc_word_t periphAOut,
    input  wire pioc_pkg::pioc_word_t periphAOe,
    input  wire pioc_pkg::pioc_word_t periphBOut,
    input  wire pioc_pkg::pioc_word_t periphBOe,
    // resulting pad drive
    output pioc_pkg::pioc_word_t      next_padOut,
    output pioc_pkg::pioc_word_t      next_padOe
);
    import pioc_pkg::*;

    genvar i;
    generate
        for (i = 0; i < `PIOC_LINES; i++) begin : g_line
            logic selOut;
            logic selOe;
            // a/b steers only out and oe [R8]; peripheral owns both when own is 0 [R11]
            assign selOut = ownCtl[i] ? level[i] : (choiceB[i] ? periphBOut[i] : periphAOut[i]);
            assign selOe  = ownCtl[i] ? drive[i] : (choiceB[i] ? periphBOe[i] : periphAOe[i]); // [R12]
            // open drain only pulls low [R15]
            assign next_padOut[i] = openDrain[i] ? 1'b0 : selOut;
            assign next_padOe[i]  = openDrain[i] ? (selOe & ~selOut) : selOe;
        end
    endgenerate

endmodule // pioc_pad_mux

`default_nettype wire

// ---- logic/pioc_line_ctrl.sv ----
// top of the 32-line parallel input/output controller
//
// Behaviour
// R1 - configuration writes are stored even while the peripheral clock is gated
// R2 - sampling, change detection and interrupt run only with the clock enabled
// R3 - pull-up enable clears off-status bits, disable sets them; 1 means off
// R4 - after reset every pull-up is on, off-status reads zero
// R5 - own-set gives lines to controller, own-clear to the chosen peripheral
// R6 - lines without a peripheral ignore ownership writes and read owned
// R7 - first select clears choice bits, second select sets them; 1 means b
// R8 - a/b choice steers only output paths; peripherals always see the pin
// R9 - after reset the choice reads zero, peripheral a on every line
// R10 - software hands a line over by a/b select plus own-clear
// R11 - peripheral-owned lines take enable and level from chosen peripheral
// R12 - drive set/clear works in any ownership; 1 drives the line
// R13 - level set/clear works in any ownership to preset first level
// R14 - direct level write touches only masked bits; mask resets to zero
// R15 - open-drain lines only pull low, otherwise released
// R16 - after reset open drain is off on every line
// R17 - readback shows pin levels, holding last sample while clock is gated
// R18 - filter drops sub half-cycle glitches and passes full-cycle pulses; the extra stage only delays, so a sampled glitch passes
// R19 - filter adds one cycle latency for changes sampled at rising edge
// R20 - filter enable set/clear; filtering affects only readback and change detect
// R21 - irq enable set/clear; changes found by two successive samples
// R22 - change sets event bit; interrupt is or of event and mask
// R23 - reading event status returns pending bits and clears them together
// R24 - unimplemented lines ignore writes and read zero
`timescale 1ns/1ps
`default_nettype none
`include "pioc_map.svh"

module pioc_line_ctrl (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // peripheral clock enable from the power manager
    input  wire logic                 periphClkEn,
    // configuration write port
    input  wire logic                 wrValid,
    input  wire pioc_pkg::pioc_cmd_t  wrCmd,
    input  wire pioc_pkg::pioc_word_t wrData,
    // event status read port
    input  wire logic                 evtReadReq,
    output pioc_pkg::pioc_word_t      evtReadData,
    // status views
    output pioc_pkg::pioc_word_t      lineOwnStatus,
    output pioc_pkg::pioc_word_t      periphChoiceStatus,
    output pioc_pkg::pioc_word_t      driveStatus,
    output pioc_pkg::pioc_word_t      levelStatus,
    output pioc_pkg::pioc_word_t      directWriteMaskStatus,
    output pioc_pkg::pioc_word_t      openDrainStatus,
    output pioc_pkg::pioc_word_t      pullupOffStatus,
    output pioc_pkg::pioc_word_t      filterEnableStatus,
    output pioc_pkg::pioc_word_t      changeIrqMask,
    output pioc_pkg::pioc_word_t      pinLevelReadback,
    // interrupt
    output logic                      changeIrq,
    // pads
    input  wire pioc_pkg::pioc_word_t padIn,
    output pioc_pkg::pioc_word_t      padOut,
    output pioc_pkg::pioc_word_t      padOe,
    output pioc_pkg::pioc_word_t      padPullupEn,
    // peripherals a and b
    input  wire pioc_pkg::pioc_word_t periphAOut,
    input  wire pioc_pkg::pioc_word_t periphAOe,
    input  wire pioc_pkg::pioc_word_t periphBOut,
    input  wire pioc_pkg::pioc_word_t periphBOe,
    output pioc_pkg::pioc_word_t      periphIn
);
    import pioc_pkg::*;

    pioc_word_t wrSet;
    pioc_word_t cleanIn;
    pioc_word_t next_padOut;
    pioc_word_t next_padOe;
    pioc_word_t changed;
    pioc_word_t eventPending;
    pioc_word_t next_event;
    logic       sampleValid;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // bits of unimplemented lines never take effect [R24]
    assign wrSet = wrData & `PIOC_IMPL_MASK;

    function automatic logic hit(input pioc_cmd_t c);
        hit = wrValid && (wrCmd == c);
    endfunction

    // ------------------------------------------------------------
    // pull-up control
    // ------------------------------------------------------------
    // config registers ignore periphClkEn [R1]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pullupOffStatus <= `PIOC_PULLOFF_RST; // [R4]
        end else if (hit(PIOC_CMD_PULL_ON)) begin
            pullupOffStatus <= pullupOffStatus & ~wrSet; // [R3]
        end else if (hit(PIOC_CMD_PULL_OFF)) begin
            pullupOffStatus <= pullupOffStatus | wrSet; // [R3]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            padPullupEn <= ~`PIOC_PULLOFF_RST & `PIOC_IMPL_MASK;
        end else if (hit(PIOC_CMD_PULL_ON)) begin
            padPullupEn <= (~pullupOffStatus | wrSet) & `PIOC_IMPL_MASK; // [R3]
        end else if (hit(PIOC_CMD_PULL_OFF)) begin
            padPullupEn <= ~(pullupOffStatus | wrSet) & `PIOC_IMPL_MASK; // [R3]
        end
    end

    // ------------------------------------------------------------
    // ownership
    // ------------------------------------------------------------
    // non-multiplexed lines stay owned, unimplemented read zero [R6] [R24]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lineOwnStatus <= `PIOC_OWN_RST & `PIOC_IMPL_MASK;
        end else if (hit(PIOC_CMD_OWN_SET)) begin
            lineOwnStatus <= ((lineOwnStatus | wrSet) & `PIOC_MUX_MASK) | (`PIOC_IMPL_MASK & ~`PIOC_MUX_MASK); // [R5]
        end else if (hit(PIOC_CMD_OWN_CLR)) begin
            lineOwnStatus <= ((lineOwnStatus & ~wrSet) & `PIOC_MUX_MASK) | (`PIOC_IMPL_MASK & ~`PIOC_MUX_MASK); // [R5]
        end
    end

    // ------------------------------------------------------------
    // peripheral a/b choice
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            periphChoiceStatus <= `PIOC_CHOICE_RST; // [R9]
        end else if (hit(PIOC_CMD_PERIPH_A)) begin
            periphChoiceStatus <= periphChoiceStatus & ~wrSet; // [R7]
        end else if (hit(PIOC_CMD_PERIPH_B)) begin
            periphChoiceStatus <= periphChoiceStatus | wrSet; // [R7]
        end
    end

    // ------------------------------------------------------------
    // output enable
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            driveStatus <= `PIOC_DRIVE_RST;
        end else if (hit(PIOC_CMD_DRIVE_SET)) begin
            driveStatus <= driveStatus | wrSet; // [R12]
        end else if (hit(PIOC_CMD_DRIVE_CLR)) begin
            driveStatus <= driveStatus & ~wrSet; // [R12]
        end
    end

    // ------------------------------------------------------------
    // output level and masked direct write
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            levelStatus <= `PIOC_LEVEL_RST;
        end else if (hit(PIOC_CMD_LEVEL_SET)) begin
            levelStatus <= levelStatus | wrSet; // [R13]
        end else if (hit(PIOC_CMD_LEVEL_CLR)) begin
            levelStatus <= levelStatus & ~wrSet; // [R13]
        end else if (hit(PIOC_CMD_LEVEL_DIRECT)) begin
            levelStatus <= (levelStatus & ~directWriteMaskStatus) | (wrSet & directWriteMaskStatus); // [R14]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            directWriteMaskStatus <= `PIOC_MASK_RST; // [R14]
        end else if (hit(PIOC_CMD_WMASK_SET)) begin
            directWriteMaskStatus <= directWriteMaskStatus | wrSet; // [R14]
        end else if (hit(PIOC_CMD_WMASK_CLR)) begin
            directWriteMaskStatus <= directWriteMaskStatus & ~wrSet; // [R14]
        end
    end

    // ------------------------------------------------------------
    // open drain
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            openDrainStatus <= `PIOC_OD_RST; // [R16]
        end else if (hit(PIOC_CMD_OD_SET)) begin
            openDrainStatus <= openDrainStatus | wrSet; // [R15]
        end else if (hit(PIOC_CMD_OD_CLR)) begin
            openDrainStatus <= openDrainStatus & ~wrSet; // [R15]
        end
    end

    // ------------------------------------------------------------
    // filter and interrupt enables
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filterEnableStatus <= `PIOC_FILT_RST;
        end else if (hit(PIOC_CMD_FILT_SET)) begin
            filterEnableStatus <= filterEnableStatus | wrSet; // [R20]
        end else if (hit(PIOC_CMD_FILT_CLR)) begin
            filterEnableStatus <= filterEnableStatus & ~wrSet; // [R20]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            changeIrqMask <= `PIOC_IRQM_RST;
        end else if (hit(PIOC_CMD_IRQ_SET)) begin
            changeIrqMask <= changeIrqMask | wrSet; // [R21]
        end else if (hit(PIOC_CMD_IRQ_CLR)) begin
            changeIrqMask <= changeIrqMask & ~wrSet; // [R21]
        end
    end

    // ------------------------------------------------------------
    // pad drive
    // ------------------------------------------------------------
    pioc_pad_mux u_pad_mux (
        .ownCtl      (lineOwnStatus),
        .choiceB     (periphChoiceStatus),
        .drive       (driveStatus),
        .level       (levelStatus),
        .openDrain   (openDrainStatus),
        .periphAOut  (periphAOut),
        .periphAOe   (periphAOe),
        .periphBOut  (periphBOut),
        .periphBOe   (periphBOe),
        .next_padOut (next_padOut),
        .next_padOe  (next_padOe)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            padOut <= `PIOC_LEVEL_RST;
            padOe  <= `PIOC_DRIVE_RST;
        end else begin
            padOut <= next_padOut & `PIOC_IMPL_MASK;
            padOe  <= next_padOe & `PIOC_IMPL_MASK;
        end
    end

    // peripherals always see the unfiltered pin [R8] [R20]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            periphIn <= `PIOC_LEVEL_RST;
        end else begin
            periphIn <= padIn & `PIOC_IMPL_MASK;
        end
    end

    // ------------------------------------------------------------
    // input sampling and filtering
    // ------------------------------------------------------------
    pioc_glitch_filter u_filter (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .sampleEn (periphClkEn),
        .rawIn    (padIn & `PIOC_IMPL_MASK),
        .filterOn (filterEnableStatus),
        .cleanOut (cleanIn)
    );

    // readback holds its last sample while the clock is gated [R17] [R2]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinLevelReadback <= `PIOC_LEVEL_RST;
            sampleValid      <= 1'b0;
        end else if (periphClkEn) begin
            pinLevelReadback <= cleanIn; // [R17] [R20]
            sampleValid      <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // change detection and event status
    // ------------------------------------------------------------
    // two successive samples compared; first sample after reset makes none [R21]
    assign changed = (periphClkEn && sampleValid) ? (cleanIn ^ pinLevelReadback) : `PIOC_EVT_RST; // [R2]

    // a change in the read cycle survives the clear [R23]
    assign next_event = (evtReadReq ? `PIOC_EVT_RST : eventPending) | changed; // [R22]

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eventPending <= `PIOC_EVT_RST;
        end else begin
            eventPending <= next_event; // [R22] [R23]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evtReadData <= `PIOC_EVT_RST;
        end else if (evtReadReq) begin
            evtReadData <= eventPending; // [R23]
        end
    end

    // single interrupt, or over all lines [R22]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            changeIrq <= 1'b0;
        end else begin
            changeIrq <= |(next_event & changeIrqMask) & (periphClkEn | changeIrq); // [R22] [R2]
        end
    end

endmodule // pioc_line_ctrl

`default_nettype wire

// ---- tb/pioc_line_ctrl_properties.sv ----
// port assertions of the line controller
`timescale 1ns/1ps
`default_nettype none
`include "pioc_map.svh"
module pioc_line_ctrl_properties
    import pioc_pkg::*;
(
    // ----
    // watched ports
    // ----
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic                 periphClkEn,
    input wire logic                 wrValid,
    input wire pioc_pkg::pioc_cmd_t  wrCmd,
    input wire pioc_pkg::pioc_word_t wrData,
    input wire logic                 evtReadReq,
    input wire pioc_pkg::pioc_word_t lineOwnStatus,
    input wire pioc_pkg::pioc_word_t periphChoiceStatus,
    input wire pioc_pkg::pioc_word_t driveStatus,
    input wire pioc_pkg::pioc_word_t levelStatus,
    input wire pioc_pkg::pioc_word_t directWriteMaskStatus,
    input wire pioc_pkg::pioc_word_t openDrainStatus,
    input wire pioc_pkg::pioc_word_t pullupOffStatus,
    input wire pioc_pkg::pioc_word_t pinLevelReadback,
    input wire logic                 changeIrq,
    input wire pioc_pkg::pioc_word_t padIn,
    input wire pioc_pkg::pioc_word_t padOut,
    input wire pioc_pkg::pioc_word_t periphIn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_reset_vals: assert property (
        $past(sys_rst) |-> (pullupOffStatus | periphChoiceStatus | openDrainStatus) == 32'h0)
        else $error("status not cleared by reset");
    chk_own_fixed: assert property (
        (lineOwnStatus | `PIOC_MUX_MASK) == 32'hffffffff) else $error("plain line not owned");
    chk_choice_a: assert property (
        wrValid && wrCmd == PIOC_CMD_PERIPH_A |=> (periphChoiceStatus & $past(wrData)) == 32'h0)
        else $error("peripheral a select ignored");
    chk_drive_set: assert property (
        wrValid && wrCmd == PIOC_CMD_DRIVE_SET |=> (driveStatus & $past(wrData)) == $past(wrData))
        else $error("drive set ignored");
    chk_direct_mask: assert property (
        wrValid && wrCmd == PIOC_CMD_LEVEL_DIRECT |=> levelStatus == (($past(levelStatus)
        & ~$past(directWriteMaskStatus)) | ($past(wrData) & $past(directWriteMaskStatus))))
        else $error("direct write not masked");
    chk_periph_in: assert property (
        !$past(sys_rst) |-> periphIn == $past(padIn)) else $error("peripheral input wrong");
    chk_gated_hold: assert property (
        !periphClkEn |=> $stable(pinLevelReadback)) else $error("readback moved while gated");
    chk_gated_irq: assert property (
        !periphClkEn && !evtReadReq && !wrValid |=> $stable(changeIrq))
        else $error("interrupt moved while gated");
    chk_read_clear: assert property (
        evtReadReq && !periphClkEn |=> !changeIrq) else $error("read left interrupt set");
    chk_open_drain: assert property (
        !$past(sys_rst) |-> (padOut & $past(openDrainStatus)) == 32'h0)
        else $error("open drain line driven high");
endmodule // pioc_line_ctrl_properties

bind pioc_line_ctrl pioc_line_ctrl_properties u_props (.clk, .sys_rst, .periphClkEn, .wrValid,
    .wrCmd, .wrData, .evtReadReq, .lineOwnStatus, .periphChoiceStatus, .driveStatus, .levelStatus,
    .directWriteMaskStatus, .openDrainStatus, .pullupOffStatus, .pinLevelReadback, .changeIrq,
    .padIn, .padOut, .periphIn);
`default_nettype wire

// ---- tb/pioc_pin_model.sv ----
// pins and peripherals a and b beside the controller
`timescale 1ns/1ps
`default_nettype none
module pioc_pin_model
    import pioc_pkg::*;
(
    // clock
    input wire logic                 clk,
    // pad side
    input wire pioc_pkg::pioc_word_t padOut,
    input wire pioc_pkg::pioc_word_t padOe,
    input wire pioc_pkg::pioc_word_t padPullupEn,
    output pioc_pkg::pioc_word_t     padIn,
    // outside drivers set by the bench
    input wire pioc_pkg::pioc_word_t extEn,
    input wire pioc_pkg::pioc_word_t extLvl,
    // peripheral output paths
    output pioc_pkg::pioc_word_t     periphAOut,
    output pioc_pkg::pioc_word_t     periphAOe,
    output pioc_pkg::pioc_word_t     periphBOut,
    output pioc_pkg::pioc_word_t     periphBOe
);
    pioc_word_t prevIn = 32'h0;
    assign periphAOut = 32'haaaaaaaa;
    assign periphAOe  = 32'hffffffff;
    assign periphBOut = 32'h55555555;
    assign periphBOe  = 32'h0000ffff;
    // controller, outside driver, pull-up; a floating line drifts
    assign padIn = (padOe & padOut) | (~padOe & extEn & extLvl) | (~padOe & ~extEn & padPullupEn)
        | (~padOe & ~extEn & ~padPullupEn & ~prevIn);
    always @(posedge clk) prevIn <= padIn;
endmodule // pioc_pin_model
`default_nettype wire

// ---- tb/pioc_line_ctrl_bench.sv ----
// self-checking bench of the line controller
`timescale 1ns/1ps
`default_nettype none
`include "pioc_map.svh"
module pioc_line_ctrl_bench;
    import pioc_pkg::*;
    logic       clk = 1'b0, sys_rst = 1'b1, periphClkEn = 1'b0, wrValid = 1'b0, evtReadReq = 1'b0;
    pioc_cmd_t  wrCmd = PIOC_CMD_NONE;
    pioc_word_t wrData = 32'h0, extEn = 32'h0, extLvl = 32'h0;
    pioc_word_t evtReadData, lineOwnStatus, periphChoiceStatus, driveStatus, levelStatus;
    pioc_word_t directWriteMaskStatus, openDrainStatus, pullupOffStatus, filterEnableStatus;
    pioc_word_t changeIrqMask, pinLevelReadback, padIn, padOut, padOe, padPullupEn, periphIn;
    pioc_word_t periphAOut, periphAOe, periphBOut, periphBOe;
    logic       changeIrq;
    int         failCount = 0, nCompared = 0;

    pioc_line_ctrl dut (.clk, .sys_rst, .periphClkEn, .wrValid, .wrCmd, .wrData, .evtReadReq,
        .evtReadData, .lineOwnStatus, .periphChoiceStatus, .driveStatus, .levelStatus,
        .directWriteMaskStatus, .openDrainStatus, .pullupOffStatus, .filterEnableStatus,
        .changeIrqMask, .pinLevelReadback, .changeIrq, .padIn, .padOut, .padOe, .padPullupEn,
        .periphAOut, .periphAOe, .periphBOut, .periphBOe, .periphIn);
    pioc_pin_model partner (.clk, .padOut, .padOe, .padPullupEn, .padIn, .extEn, .extLvl,
        .periphAOut, .periphAOe, .periphBOut, .periphBOe);

    initial forever #50 clk = ~clk;

    // ----
    // shared tasks
    // ----
    task automatic completeRun();
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input pioc_word_t got, input pioc_word_t exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input pioc_cmd_t c, input pioc_word_t d);
        wrValid = 1'b1;
        wrCmd = c;
        wrData = d;
        tick(1);
        wrValid = 1'b0;
        tick(1);
    endtask
    task automatic readEvents();
        evtReadReq = 1'b1;
        tick(1);
        evtReadReq = 1'b0;
        tick(1);
    endtask
    task automatic waitIrq();
        int n;
        n = 0;
        while (changeIrq !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        check({31'h0, changeIrq}, 32'h1);
        if (changeIrq !== 1'b1) completeRun();
    endtask
    task automatic doReset();
        sys_rst = 1'b1;
        tick(16);
        sys_rst = 1'b0;
    endtask
    function automatic pioc_word_t statusOf(input int i);
        case (i)
            0: return pullupOffStatus;
            1: return periphChoiceStatus;
            2: return driveStatus;
            3: return levelStatus;
            4: return directWriteMaskStatus;
            5: return openDrainStatus;
            6: return filterEnableStatus;
            default: return changeIrqMask;
        endcase
    endfunction

    // ----
    // scenarios
    // ----
    task automatic testSetClear();
        pioc_cmd_t setC [8] = '{PIOC_CMD_PULL_OFF, PIOC_CMD_PERIPH_B, PIOC_CMD_DRIVE_SET,
            PIOC_CMD_LEVEL_SET, PIOC_CMD_WMASK_SET, PIOC_CMD_OD_SET, PIOC_CMD_FILT_SET, PIOC_CMD_IRQ_SET};
        pioc_cmd_t clrC [8] = '{PIOC_CMD_PULL_ON, PIOC_CMD_PERIPH_A, PIOC_CMD_DRIVE_CLR,
            PIOC_CMD_LEVEL_CLR, PIOC_CMD_WMASK_CLR, PIOC_CMD_OD_CLR, PIOC_CMD_FILT_CLR, PIOC_CMD_IRQ_CLR};
        check(pullupOffStatus | periphChoiceStatus | openDrainStatus | directWriteMaskStatus, 32'h0);
        check(lineOwnStatus, `PIOC_OWN_RST);
        for (int i = 0; i < 8; i++) begin
            wr(setC[i], 32'hf0f000ff);
            check(statusOf(i), 32'hf0f000ff);
            wr(clrC[i], 32'h00f0000f);
            check(statusOf(i), 32'hf00000f0);
        end
        check(padPullupEn, 32'h0fffff0f);
        wr(PIOC_CMD_OWN_CLR, 32'hffffffff);
        check(lineOwnStatus, ~`PIOC_MUX_MASK);
        wr(PIOC_CMD_OWN_SET, 32'h0000ffff);
        check(lineOwnStatus, ~`PIOC_MUX_MASK | 32'h0000ffff);
    endtask
    task automatic testDirect();
        wr(PIOC_CMD_WMASK_SET, 32'h0000000f);
        wr(PIOC_CMD_LEVEL_SET, 32'h000000f0);
        wr(PIOC_CMD_LEVEL_DIRECT, 32'h5a5a5a5a);
        check(levelStatus, 32'h000000fa);
        wr(PIOC_CMD_WMASK_CLR, 32'h0000000f);
        wr(PIOC_CMD_LEVEL_DIRECT, 32'h0);
        check(levelStatus, 32'h000000fa);
    endtask
    task automatic testPads();
        periphClkEn = 1'b1;
        wr(PIOC_CMD_LEVEL_SET, 32'h0000000f);
        wr(PIOC_CMD_OD_SET, 32'h00000003);
        wr(PIOC_CMD_DRIVE_SET, 32'h000000ff);
        check(padOe, 32'h000000fc);
        check(padOut, 32'h0000000c);
        wr(PIOC_CMD_PERIPH_B, 32'h000f0000);
        wr(PIOC_CMD_OWN_CLR, 32'h00ff0000);
        check(padOe, 32'h00f000fc);
        check(padOut & padOe, 32'h00a0000c);
        tick(1);
        check(pinLevelReadback, 32'hffafff0f);
        check(periphIn, 32'hffafff0f);
    endtask
    task automatic testChange();
        periphClkEn = 1'b1;
        wr(PIOC_CMD_IRQ_SET, 32'h00000100);
        wr(PIOC_CMD_FILT_SET, 32'h00000100);
        readEvents();
        extEn = 32'h00000300;
        extLvl = 32'h0;
        tick(1);
        check(periphIn & 32'h300, 32'h0);
        check(pinLevelReadback & 32'h300, 32'h100);
        tick(1);
        check(pinLevelReadback & 32'h300, 32'h0);
        waitIrq();
        readEvents();
        check(evtReadData, 32'h00000300);
        check({31'h0, changeIrq}, 32'h0);
        extEn = 32'h00000100;
        tick(4);
        check({31'h0, changeIrq}, 32'h0);
        readEvents();
        check(evtReadData, 32'h00000200);
    endtask
    task automatic testGated();
        periphClkEn = 1'b0;
        wr(PIOC_CMD_IRQ_SET, 32'h00000400);
        extEn = 32'h00000500;
        tick(4);
        check({31'h0, changeIrq}, 32'h0);
        check(pinLevelReadback & 32'h400, 32'h400);
        periphClkEn = 1'b1;
        waitIrq();
        periphClkEn = 1'b0;
        readEvents();
        check(evtReadData, 32'h00000400);
    endtask

    initial begin
        doReset();
        testSetClear();
        doReset();
        testDirect();
        doReset();
        testPads();
        doReset();
        testChange();
        testGated();
        completeRun();
    end
endmodule // pioc_line_ctrl_bench
`default_nettype wire
